// [design/asrc_ctrl.sv]
// Purpose: Host controller that drives an asynchronous 16-bit static RAM.
// Assumes: One clock; the RAM data bus returns through three flip-flops.
// Notes: One request at a time; a retention request parks the RAM deselected.
`timescale 1ns/100ps
module asrc_ctrl #(
    parameter int POWER_UP_CYCLES = asrc_pkg::POWER_UP_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [asrc_pkg::ADDR_W-1:0] req_addr,
    input wire logic [asrc_pkg::DATA_W-1:0] req_wdata,
    input wire logic [1:0] req_lane_n,
    input wire logic retain_req,
    output logic req_ready,
    output logic rsp_valid,
    output logic [asrc_pkg::DATA_W-1:0] rsp_rdata,
    output logic retain_ack,
    output logic [asrc_pkg::ADDR_W-1:0] ram_addr,
    input wire logic [asrc_pkg::DATA_W-1:0] ram_data_i,
    output logic [asrc_pkg::DATA_W-1:0] ram_data_o,
    output logic ram_data_oe_n,
    output logic chip_select_active_low,
    output logic chip_select_active_high,
    output logic write_strobe_n,
    output logic output_strobe_n,
    output logic upper_byte_lane_enable,
    output logic lower_byte_lane_enable
);
    import asrc_pkg::*;

    asrc_state_e state_ff;
    logic [17:0] pwr_cnt_ff;
    logic [7:0] cnt_ff;
    logic [DATA_W-1:0] sync1_ff, sync2_ff, sync3_ff;
    logic [DATA_W-1:0] rdata_seen_ff;

    function automatic logic cnt_done(input logic [7:0] c);
        return c == 8'h01;
    endfunction

    // Three-stage capture; the read window is long, so settled data is taken.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            sync3_ff <= '0;
        end else begin
            sync1_ff <= ram_data_i;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    // A new bus value counts only once the last two stages agree, so a word
    // caught mid-change is never handed to the requester.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_seen_ff <= '0;
        end else if (sync2_ff == sync3_ff) begin
            rdata_seen_ff <= sync3_ff;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pwr_cnt_ff <= 18'h00000;
        end else if (state_ff == ASRC_POWERUP) begin
            pwr_cnt_ff <= pwr_cnt_ff + 18'h00001;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= ASRC_POWERUP;
            cnt_ff <= 8'h00;
        end else begin
            case (state_ff)
                ASRC_POWERUP: begin
                    if (pwr_cnt_ff >= 18'(POWER_UP_CYCLES - 1)) begin
                        state_ff <= ASRC_IDLE;
                    end
                end
                ASRC_IDLE: begin
                    if (retain_req) begin
                        state_ff <= ASRC_RETAIN;
                    end else if (req_valid) begin
                        state_ff <= req_write ? ASRC_WRITE : ASRC_READ;
                        // Extra cycles cover address read delay plus sync stages.
                        cnt_ff <= req_write ? WRITE_LEN : READ_LEN + 8'h03;
                    end
                end
                ASRC_READ, ASRC_WRITE: begin
                    cnt_ff <= cnt_ff - 8'h01;
                    if (cnt_done(cnt_ff)) begin
                        state_ff <= ASRC_HOLD;
                        cnt_ff <= GAP_LEN;
                    end
                end
                ASRC_HOLD: begin
                    cnt_ff <= cnt_ff - 8'h01;
                    if (cnt_done(cnt_ff)) begin
                        state_ff <= ASRC_IDLE;
                    end
                end
                ASRC_RETAIN: begin
                    if (!retain_req) begin
                        state_ff <= ASRC_RECOVER;
                        cnt_ff <= RECOVER_LEN;
                    end
                end
                ASRC_RECOVER: begin
                    cnt_ff <= cnt_ff - 8'h01;
                    if (cnt_done(cnt_ff)) begin
                        state_ff <= ASRC_IDLE;
                    end
                end
                default: state_ff <= ASRC_IDLE;
            endcase
        end
    end

    // Pin drive. Address, data and lanes are set at request time and held
    // through the hold cycle, so they start with the write strobe and stay at least one cycle past its end.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ram_addr <= '0;
            ram_data_o <= '0;
            ram_data_oe_n <= 1'b1;
            chip_select_active_low <= 1'b1;
            chip_select_active_high <= 1'b0;
            write_strobe_n <= 1'b1;
            output_strobe_n <= 1'b1;
            upper_byte_lane_enable <= 1'b1;
            lower_byte_lane_enable <= 1'b1;
        end else begin
            if (state_ff == ASRC_IDLE && req_valid && !retain_req) begin
                ram_addr <= req_addr;
                ram_data_o <= req_wdata;
                ram_data_oe_n <= !req_write;
                // Selects and lanes move together so lanes never toggle alone.
                chip_select_active_low <= 1'b0;
                chip_select_active_high <= 1'b1;
                upper_byte_lane_enable <= req_lane_n[1];
                lower_byte_lane_enable <= req_lane_n[0];
                write_strobe_n <= !req_write;
                output_strobe_n <= req_write;
            end else if ((state_ff == ASRC_READ || state_ff == ASRC_WRITE) &&
                         cnt_done(cnt_ff)) begin
                write_strobe_n <= 1'b1;
                output_strobe_n <= 1'b1;
            end else if (state_ff == ASRC_HOLD && cnt_done(cnt_ff)) begin
                ram_data_oe_n <= 1'b1;
                chip_select_active_low <= 1'b1;
                chip_select_active_high <= 1'b0;
                upper_byte_lane_enable <= 1'b1;
                lower_byte_lane_enable <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
            retain_ack <= 1'b0;
        end else begin
            req_ready <= state_ff == ASRC_IDLE && !req_valid && !retain_req;
            rsp_valid <= state_ff == ASRC_READ && cnt_done(cnt_ff);
            if (state_ff == ASRC_READ && cnt_done(cnt_ff)) begin
                rsp_rdata <= rdata_seen_ff;
            end
            retain_ack <= state_ff == ASRC_RETAIN;
        end
    end

    a_write_strobe_width: assert property (@(posedge clk) disable iff (!rstn)
        $fell(write_strobe_n) |-> !write_strobe_n [*4])
        else $error("write strobe pulse too short");
    a_write_data_drive: assert property (@(posedge clk) disable iff (!rstn)
        !write_strobe_n |-> !ram_data_oe_n && output_strobe_n)
        else $error("data not driven during write");
    a_write_select_held: assert property (@(posedge clk) disable iff (!rstn)
        $rose(write_strobe_n) |-> !chip_select_active_low && $stable(ram_addr))
        else $error("select or address lost at write end");
    a_read_strobes: assert property (@(posedge clk) disable iff (!rstn)
        !output_strobe_n |-> write_strobe_n && ram_data_oe_n)
        else $error("read with write strobe low");
    a_lanes_deselect: assert property (@(posedge clk) disable iff (!rstn)
        chip_select_active_low && $past(chip_select_active_low) |->
        $stable(upper_byte_lane_enable) && $stable(lower_byte_lane_enable))
        else $error("lane toggled while deselected");
    a_retain_desel: assert property (@(posedge clk) disable iff (!rstn)
        retain_ack |-> chip_select_active_low && !chip_select_active_high)
        else $error("selected during retention");
    a_access_spacing: assert property (@(posedge clk) disable iff (!rstn)
        $fell(chip_select_active_low) |=> !chip_select_active_low [*4])
        else $error("access shorter than cycle time");
    a_powerup_quiet: assert property (@(posedge clk) disable iff (!rstn)
        state_ff == ASRC_POWERUP |-> chip_select_active_low && !req_ready)
        else $error("access during power up wait");
    a_recover_quiet: assert property (@(posedge clk) disable iff (!rstn)
        $fell(retain_ack) |-> chip_select_active_low [*4])
        else $error("access before recovery");

    c_write: cover property (@(posedge clk) $rose(write_strobe_n));
    c_read: cover property (@(posedge clk) rsp_valid);
    c_retain: cover property (@(posedge clk) $fell(retain_ack));
endmodule // asrc_ctrl

// [design/asrc_pkg.sv]
// Purpose: Constants for the asynchronous static RAM controller.
// Assumes: 100 MHz clock, 10 ns period.
// Notes: Times are in ns or us as printed; cycle counts derive from them.
package asrc_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 16;
    localparam int READ_CYCLE_TIME_NS = 45;
    localparam int WRITE_CYCLE_TIME_NS = 45;
    localparam int ADDRESS_ACCESS_DELAY_NS = 45;
    localparam int OUTPUT_STROBE_ACCESS_DELAY_NS = 22;
    localparam int BYTE_LANE_ACCESS_DELAY_NS = 45;
    localparam int WRITE_STROBE_PULSE_WIDTH_NS = 35;
    localparam int DATA_SETUP_TO_WRITE_END_NS = 25;
    localparam int POWER_UP_WAIT_US = 200;
    // Least times round up to whole cycles.
    localparam int READ_CYC = (READ_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_CYC = (WRITE_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACCESS_CYC = (ADDRESS_ACCESS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_CYC =
        (WRITE_STROBE_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_CYC =
        (DATA_SETUP_TO_WRITE_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POWER_UP_CYC = POWER_UP_WAIT_US * 1000 / CLK_PERIOD_NS;
    localparam logic [7:0] READ_LEN = 8'(ACCESS_CYC + 1);
    localparam logic [7:0] WRITE_LEN = 8'(STROBE_CYC);
    // One hold cycle keeps address, data and selects past the strobe edge.
    localparam logic [7:0] GAP_LEN = 8'h01;
    localparam logic [7:0] RECOVER_LEN = 8'(READ_CYC);
    typedef enum logic [2:0] {
        ASRC_POWERUP = 3'h0,
        ASRC_IDLE = 3'h1,
        ASRC_READ = 3'h3,
        ASRC_WRITE = 3'h2,
        ASRC_HOLD = 3'h6,
        ASRC_RETAIN = 3'h7,
        ASRC_RECOVER = 3'h5
    } asrc_state_e;
endpackage

// [test/asrc_ram_model.sv]
// Purpose: Behavioural static RAM on the far side of the controller.
// Assumes: 256 words suffice; upper address bits fold onto them.
// Notes: A bus that nobody drives shows the inverse of the last read word.
`timescale 1ns/100ps
module asrc_ram_model (
    input wire logic [asrc_pkg::ADDR_W-1:0] addr,
    input wire logic ce_n,
    input wire logic ce,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic [1:0] lane_n,
    input wire logic [asrc_pkg::DATA_W-1:0] host_data,
    input wire logic host_oe_n,
    output logic [asrc_pkg::DATA_W-1:0] bus,
    output logic clash
);
    import asrc_pkg::*;
    logic [15:0] mem [0:255];
    logic [15:0] last = 16'h0000;
    logic rd_late;
    logic [ADDR_W-1:0] addr_late;
    logic [ADDR_W-1:0] addr_recent;
    localparam int OLD_DATA_HOLD_NS = 10;
    wire sel = !ce_n && ce && (lane_n != 2'b11);
    wire wr = sel && !we_n;
    wire rd = sel && we_n && !oe_n;
    // Inertial delays hide data until it has settled for the full access time.
    assign #(ADDRESS_ACCESS_DELAY_NS) rd_late = rd;
    // The previous word lingers briefly after an address move.
    assign #(OLD_DATA_HOLD_NS) addr_recent = addr;
    wire keep_old = rd && (addr_recent != addr);
    assign #(ADDRESS_ACCESS_DELAY_NS) addr_late = addr;
    wire valid = rd && rd_late && (addr_late == addr);
    wire [15:0] word = mem[addr[7:0]];
    always @(wr, lane_n, addr, host_data) begin
        if (wr && !lane_n[0]) mem[addr[7:0]][7:0] = host_data[7:0];
        if (wr && !lane_n[1]) mem[addr[7:0]][15:8] = host_data[15:8];
    end
    always @(valid, word) if (valid) last = word;
    always @* begin
        bus = ~last;
        if (keep_old) bus = last;
        if (valid && !lane_n[0]) bus[7:0] = word[7:0];
        if (valid && !lane_n[1]) bus[15:8] = word[15:8];
        if (!host_oe_n) bus = host_data;
    end
    assign clash = !host_oe_n && rd;
endmodule // asrc_ram_model

// [test/asrc_ctrl_tb.sv]
// Purpose: Self-checking bench for the static RAM controller.
// Assumes: Power-up wait shortened to 10 cycles.
// Notes: Clash is sampled at the falling edge to skip zero-time glitches.
`timescale 1ns/100ps
module asrc_ctrl_tb;
    import asrc_pkg::*;
    localparam int PWR = 10;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic req_valid = 1'b0, req_write = 1'b0, retain_req = 1'b0;
    logic [ADDR_W-1:0] req_addr = '0, ram_addr;
    logic [DATA_W-1:0] req_wdata = '0, rsp_rdata, ram_data_o, ram_data_i;
    logic [1:0] req_lane_n = 2'b11;
    logic req_ready, rsp_valid, retain_ack, ram_data_oe_n, write_strobe_n, output_strobe_n;
    logic chip_select_active_low, chip_select_active_high, clash;
    logic upper_byte_lane_enable, lower_byte_lane_enable;
    int n_errors = 0, tests_run = 0, cycles = 0;
    wire desel = chip_select_active_low || !chip_select_active_high;
    always #5 clk = ~clk;
    asrc_ctrl #(.POWER_UP_CYCLES(PWR)) u_asrc_ctrl (.clk, .rstn, .req_valid, .req_write,
        .req_addr, .req_wdata, .req_lane_n, .retain_req, .req_ready, .rsp_valid, .rsp_rdata,
        .retain_ack, .ram_addr, .ram_data_i, .ram_data_o, .ram_data_oe_n,
        .chip_select_active_low, .chip_select_active_high, .write_strobe_n, .output_strobe_n,
        .upper_byte_lane_enable, .lower_byte_lane_enable);
    asrc_ram_model u_asrc_ram_model (.addr(ram_addr), .ce_n(chip_select_active_low),
        .ce(chip_select_active_high), .we_n(write_strobe_n), .oe_n(output_strobe_n),
        .lane_n({upper_byte_lane_enable, lower_byte_lane_enable}), .host_data(ram_data_o),
        .host_oe_n(ram_data_oe_n), .bus(ram_data_i), .clash(clash));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("Checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(negedge clk) if (rstn) check("bus clash", 16'(clash), 16'h0000);
    always @(posedge clk) if (rstn) check("lane toggle",
        16'($past(desel) && desel && $changed({upper_byte_lane_enable, lower_byte_lane_enable})),
        16'h0000);
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            close_out();
        end
    end
    task automatic send(input logic w, input logic [ADDR_W-1:0] a, input logic [15:0] d,
        input logic [1:0] l);
        int n;
        n = 0;
        do begin @(negedge clk); n++; end while (req_ready !== 1'b1 && n < 50);
        check("ready", 16'(n < 50), 16'h0001);
        @(posedge clk);
        req_valid <= 1'b1; req_write <= w; req_addr <= a; req_wdata <= d; req_lane_n <= l;
        @(posedge clk);
        req_valid <= 1'b0;
    endtask
    task automatic do_write(input logic [ADDR_W-1:0] a, input logic [15:0] d,
        input logic [1:0] l);
        int n, bad;
        n = 0;
        bad = 0;
        send(1'b1, a, d, l);
        repeat (8) begin
            @(negedge clk);
            if (!write_strobe_n) n++;
            if (!write_strobe_n && (ram_data_o !== d || ram_data_oe_n !== 1'b0)) bad++;
            if (!write_strobe_n && ram_addr !== a) bad++;
        end
        check("strobe width", 16'(n >= STROBE_CYC), 16'h0001);
        check("data and address", 16'(bad), 16'h0000);
    endtask
    task automatic do_read(input logic [ADDR_W-1:0] a, input logic [1:0] l,
        input logic [15:0] exp, input logic [15:0] mask);
        int n;
        n = 0;
        send(1'b0, a, 16'h0000, l);
        do begin @(negedge clk); n++; end while (rsp_valid !== 1'b1 && n < 20);
        check("read word", rsp_rdata & mask, exp & mask);
        check("read wait", 16'(n >= ACCESS_CYC && n < 20), 16'h0001);
    endtask
    task automatic retention();
        int n;
        n = 0;
        @(posedge clk);
        retain_req <= 1'b1;
        do begin @(negedge clk); n++; end while (retain_ack !== 1'b1 && n < 50);
        check("retain ack", 16'(retain_ack), 16'h0001);
        repeat (20) @(negedge clk);
        check("parked", 16'({chip_select_active_low, chip_select_active_high,
            upper_byte_lane_enable, lower_byte_lane_enable}), 16'h000B);
        @(posedge clk);
        retain_req <= 1'b0;
        repeat (RECOVER_LEN - 1) @(negedge clk);
        check("recovery", 16'({req_ready, chip_select_active_low}), 16'h0001);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (PWR - 2) @(negedge clk);
        check("ready in wait", 16'(req_ready), 16'h0000);
        check("select in wait", 16'({chip_select_active_low, chip_select_active_high}),
            16'h0002);
        do_write(19'h00005, 16'hA55A, 2'b00);
        do_read(19'h00005, 2'b00, 16'hA55A, 16'hFFFF);
        do_write(19'h00005, 16'h1234, 2'b10);
        do_read(19'h00005, 2'b00, 16'hA534, 16'hFFFF);
        do_read(19'h00005, 2'b01, 16'hA500, 16'hFF00);
        do_write(19'h7FF0A, 16'h0F0F, 2'b00);
        retention();
        do_read(19'h7FF0A, 2'b00, 16'h0F0F, 16'hFFFF);
        close_out();
    end
endmodule // asrc_ctrl_tb
